//--- hpcg_defs.svh
`ifndef HPCG_DEFS_SVH
`define HPCG_DEFS_SVH

// register indices on the plain register port
`define HPCG_ADDR_W 2
`define HPCG_IDX_DIR 2'h0
`define HPCG_IDX_LEVEL 2'h1
`define HPCG_IDX_ENABLE 2'h2
`define HPCG_IDX_STATUS 2'h3

`define HPCG_REG_W 16
`define HPCG_NPINS 9
`define HPCG_RESET_VAL 16'h0000
`define HPCG_USED_MASK 16'h01ff

// pin bit positions in direction / level registers
`define HPCG_BIT_INT 8
`define HPCG_BIT_CTL0 7
`define HPCG_BIT_CTL1 6
`define HPCG_BIT_BYTE_ID 5
`define HPCG_BIT_RW 4
`define HPCG_BIT_STROBE2 3
`define HPCG_BIT_STROBE1 2
`define HPCG_BIT_CS 1
`define HPCG_BIT_ADDR_STROBE 0

// group enable bit positions
`define HPCG_EN_INT 6
`define HPCG_EN_BYTE_ID 4
`define HPCG_EN_ADDR_STROBE 2
`define HPCG_EN_CTL 1
`define HPCG_EN_STROBE 0
`define HPCG_EN_MASK 16'h0057

// status register fields
`define HPCG_ST_MUX8 0
`define HPCG_ST_STRAP 1
`define HPCG_ST_BAD_EN0 2

`endif

//--- hpcg_far_side.sv
`timescale 1ns/10ps
module hpcg_far_side
  import hpcg_pkg::*;
(
  // pins
  input wire logic [8:0] pin_out_in,
  input wire logic [8:0] pin_oe_in,
  input wire logic [8:0] ext_in,
  output logic [8:0] pin_in_out
);
  // released pins follow the outside source, so a stale drive never reads back
  assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule

//--- hpcg_gpio.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Behaviour
// (RQ1) each pin has its own direction bit, 0 input and 1 output
// (RQ2) input pin: level bit reads the pin, 0 low, 1 high
// (RQ3) input pin: writes to its level bit have no effect
// (RQ4) output pin: level bit written 0 drives low, 1 drives high
// (RQ5) pin settings act only when its group enable bit is set
// (RQ6) address strobe and byte-identify work only in 8-bit multiplexed mode
// (RQ7) chip select, strobes, read/write usable only while strap is low
// (RQ8) direction bits: 8 int, 7 ctl0, 6 ctl1, 5 byte-id, 4 rw, 3..0 strobes/cs/as
// (RQ9) level register uses the same bit-to-pin map
// (RQ10) software writes zero to reserved bits 15 to 9
// (RQ11) all bits read/write, reset to zero, pins start as inputs; the enable register keeps only bits 6, 4, 2, 1 and 0, status is read-only
// (RQ12) only the CPU port reaches the registers, not the host
// (RQ13) enable bits: 6 int, 4 byte-id, 2 addr strobe, 1 ctl, 0 strobe group
// (RQ14) software keeps enable bit 0 clear while the strap is high
module hpcg_gpio
  import hpcg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // cpu register port
  input wire logic [`HPCG_ADDR_W-1:0] addr_in,
  input wire logic [`HPCG_REG_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`HPCG_REG_W-1:0] rdata_out,
  // mode and strap
  input wire logic mux8_mode_in,
  input wire logic port_enable_strap_in,
  // control pins
  input wire logic [`HPCG_NPINS-1:0] pin_in,
  output logic [`HPCG_NPINS-1:0] pin_out,
  output logic [`HPCG_NPINS-1:0] pin_oe_out,
  // which pins are currently general-purpose
  output logic [`HPCG_NPINS-1:0] pin_gpio_out
);
  // ****************************************
  // registers
  // ****************************************
  hpcg_bus_req_t req;
  logic [`HPCG_NPINS-1:0] control_pin_direction;
  logic [`HPCG_REG_W-1:0] pin_group_gpio_enable;
  logic [`HPCG_NPINS-1:0] level_bits;
  logic [`HPCG_NPINS-1:0] usable;
  hpcg_pin_drive_t drive;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // registers sit only behind the cpu port; no host path exists
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      control_pin_direction <= '0; // RQ11
    end else if (req.wr && req.addr == `HPCG_IDX_DIR) begin
      control_pin_direction <= req.wdata[`HPCG_NPINS-1:0]; // RQ1 RQ8 RQ12
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_group_gpio_enable <= `HPCG_RESET_VAL;
    end else if (req.wr && req.addr == `HPCG_IDX_ENABLE) begin
      pin_group_gpio_enable <= req.wdata & `HPCG_EN_MASK; // RQ13
    end
  end

  // ****************************************
  // pin usability
  // ****************************************
  logic en_int;
  logic en_byte;
  logic en_as;
  logic en_ctl;
  logic en_strobe;
  assign en_int = pin_group_gpio_enable[`HPCG_EN_INT];
  assign en_byte = pin_group_gpio_enable[`HPCG_EN_BYTE_ID] && mux8_mode_in; // RQ6
  assign en_as = pin_group_gpio_enable[`HPCG_EN_ADDR_STROBE] && mux8_mode_in; // RQ6
  assign en_ctl = pin_group_gpio_enable[`HPCG_EN_CTL];
  // strap high overrides a wrongly set bit 0 so the host port keeps its pins
  assign en_strobe = pin_group_gpio_enable[`HPCG_EN_STROBE] && !port_enable_strap_in; // RQ7 RQ14

  always_comb begin
    usable = '0;
    usable[`HPCG_BIT_INT] = en_int; // RQ13
    usable[`HPCG_BIT_CTL0] = en_ctl;
    usable[`HPCG_BIT_CTL1] = en_ctl;
    usable[`HPCG_BIT_BYTE_ID] = en_byte;
    usable[`HPCG_BIT_RW] = en_strobe;
    usable[`HPCG_BIT_STROBE2] = en_strobe;
    usable[`HPCG_BIT_STROBE1] = en_strobe;
    usable[`HPCG_BIT_CS] = en_strobe;
    usable[`HPCG_BIT_ADDR_STROBE] = en_as;
  end

  // ****************************************
  // per-pin cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `HPCG_NPINS; gi = gi + 1) begin : g_pin
      hpcg_pin_cell u_cell (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .usable_in(usable[gi]),
        .wr_in(req.wr && req.addr == `HPCG_IDX_LEVEL),
        .wdata_in(req.wdata[gi]),
        .dir_in(control_pin_direction[gi]),
        .pin_in(pin_in[gi]),
        .pin_out(drive.level[gi]),
        .pin_oe_out(drive.oe[gi]),
        .level_out(level_bits[gi])
      ); // RQ5 RQ9
    end
  endgenerate

  assign pin_out = drive.level;
  assign pin_oe_out = drive.oe;
  assign pin_gpio_out = usable;

  // ****************************************
  // read data
  // ****************************************
  logic [`HPCG_REG_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (req.addr)
      `HPCG_IDX_DIR: begin
        next_rdata[`HPCG_NPINS-1:0] = control_pin_direction;
      end
      `HPCG_IDX_LEVEL: begin
        next_rdata[`HPCG_NPINS-1:0] = level_bits; // RQ2 RQ9
      end
      `HPCG_IDX_ENABLE: begin
        next_rdata = pin_group_gpio_enable;
      end
      `HPCG_IDX_STATUS: begin
        next_rdata[`HPCG_ST_MUX8] = mux8_mode_in;
        next_rdata[`HPCG_ST_STRAP] = port_enable_strap_in;
        next_rdata[`HPCG_ST_BAD_EN0] =
          pin_group_gpio_enable[`HPCG_EN_STROBE] && port_enable_strap_in; // RQ14
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (req.rd) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end
endmodule

//--- hpcg_gpio_properties.sv
`timescale 1ns/10ps
module hpcg_gpio_properties
  import hpcg_pkg::*;
(
  // clock, reset, bus
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`HPCG_ADDR_W-1:0] addr_in,
  input wire logic [`HPCG_REG_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [`HPCG_REG_W-1:0] rdata_out,
  // mode and pins
  input wire logic mux8_mode_in,
  input wire logic port_enable_strap_in,
  input wire logic [`HPCG_NPINS-1:0] pin_in,
  input wire logic [`HPCG_NPINS-1:0] pin_out,
  input wire logic [`HPCG_NPINS-1:0] pin_oe_out,
  input wire logic [`HPCG_NPINS-1:0] pin_gpio_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  rst_clear_a: assert property (!$past(rst_n_in) |-> pin_oe_out == 9'h0)
    else $error("pins driven after reset");
  oe_gated_a: assert property ((pin_oe_out & ~pin_gpio_out) == 9'h0)
    else $error("pin driven while not general purpose");
  strap_off_a: assert property (port_enable_strap_in |-> pin_gpio_out[4:1] == 4'h0)
    else $error("strobe group usable with strap high");
  mux_off_a: assert property (!mux8_mode_in |-> !pin_gpio_out[5] && !pin_gpio_out[0])
    else $error("mux-only pin usable in 16-bit mode");
  int_en_a: assert property (wr_in && addr_in == `HPCG_IDX_ENABLE |=>
    pin_gpio_out[8] == $past(wdata_in[6])) else $error("interrupt pin enable wrong");
  drive_a: assert property (wr_in && addr_in == `HPCG_IDX_LEVEL && pin_oe_out[8] |=>
    pin_out[8] == $past(wdata_in[8])) else $error("output level not driven");
  hold_a: assert property (wr_in && addr_in == `HPCG_IDX_LEVEL && pin_gpio_out[8]
    && !pin_oe_out[8] |=> $stable(pin_out[8])) else $error("input latch changed");
  in_read_a: assert property (rd_in && addr_in == `HPCG_IDX_LEVEL && pin_gpio_out[2]
    && !pin_oe_out[2] |=> rdata_out[2] == $past(pin_in[2])) else $error("input level misread");
  resv_zero_a: assert property ($past(rd_in) |-> rdata_out[15:9] == 7'h0)
    else $error("reserved bits read nonzero");
endmodule
bind hpcg_gpio hpcg_gpio_properties chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .mux8_mode_in, .port_enable_strap_in, .pin_in, .pin_out, .pin_oe_out,
  .pin_gpio_out);

//--- hpcg_gpio_tb.sv
`timescale 1ns/10ps
module hpcg_gpio_tb
  import hpcg_pkg::*;
();
  logic clk_in = 0, rst_n_in = 0, wr = 0, rd = 0, mux = 0, strap = 0, rd_seen = 0;
  logic [1:0] addr = 0;
  logic [15:0] wd = 0, rdata, lat = 0, dir, en, d, r;
  logic [8:0] ext = 0, pin_in, pin_out, oe, gpio, g;
  logic [31:0] seed = 72771;
  int fails = 0, n_compared = 0, cyc = 0;
  logic [15:0] exp_q[$];
  hpcg_gpio uut (.clk_in, .rst_n_in, .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .mux8_mode_in(mux), .port_enable_strap_in(strap), .pin_in, .pin_out,
    .pin_oe_out(oe), .pin_gpio_out(gpio));
  hpcg_far_side far (.pin_out_in(pin_out), .pin_oe_in(oe), .ext_in(ext), .pin_in_out(pin_in));
  initial forever #5 clk_in = ~clk_in;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(logic [1:0] a, logic [15:0] v);
    @(posedge clk_in);
    wr <= 1;
    addr <= a;
    wd <= v;
    @(posedge clk_in);
    wr <= 0;
  endtask
  task automatic rd_reg(logic [1:0] a, logic [15:0] e);
    @(posedge clk_in);
    exp_q.push_back(e);
    rd <= 1;
    addr <= a;
    @(posedge clk_in);
    rd <= 0;
  endtask
  task report_and_stop();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) rd_seen <= rd;
  always @(negedge clk_in) if (rd_seen) chk("rdata", exp_q.pop_front(), rdata);
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1;
    rd_reg(`HPCG_IDX_DIR, 16'h0);
    rd_reg(`HPCG_IDX_ENABLE, 16'h0);
    $display("reset test done");
    repeat (16) begin
      r = rnd();
      mux <= r[0];
      strap <= r[1];
      ext <= r[10:2];
      en = rnd() & `HPCG_EN_MASK & {15'h7fff, ~r[1]};
      dir = rnd() & `HPCG_USED_MASK;
      d = rnd() & `HPCG_USED_MASK;
      wr_reg(`HPCG_IDX_ENABLE, en);
      wr_reg(`HPCG_IDX_DIR, dir);
      wr_reg(`HPCG_IDX_LEVEL, d);
      wr_reg(`HPCG_IDX_STATUS, 16'hffff);
      lat = (lat & ~dir) | (d & dir);
      g = {en[6], en[1], en[1], en[4] & mux, {4{en[0] & ~strap}}, en[2] & mux};
      rd_reg(`HPCG_IDX_LEVEL, (lat & dir) | ({7'h0, ext} & ~dir));
      rd_reg(`HPCG_IDX_DIR, dir);
      rd_reg(`HPCG_IDX_ENABLE, en);
      rd_reg(`HPCG_IDX_STATUS, {14'h0, strap, mux});
      chk("gpio", 16'(g), 16'(gpio));
      chk("oe", 16'(g & dir[8:0]), 16'(oe));
      chk("pin_out", 16'(lat[8:0] & dir[8:0]), 16'(pin_out & dir[8:0]));
    end
    $display("random pin test done");
    // strap high must win over a wrongly set strobe group enable
    strap <= 1;
    wr_reg(`HPCG_IDX_ENABLE, `HPCG_EN_MASK);
    rd_reg(`HPCG_IDX_STATUS, {13'h0, 2'h3, mux});
    chk("gpio strobe group", 16'h0, 16'(gpio[4:1]));
    chk("gpio int", 16'h1, 16'(gpio[8]));
    $display("strap override test done");
    rst_n_in <= 0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    rd_reg(`HPCG_IDX_ENABLE, 16'h0);
    rd_reg(`HPCG_IDX_LEVEL, {7'h0, ext});
    chk("oe", 16'h0, 16'(oe));
    repeat (2) @(negedge clk_in);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule

//--- hpcg_pin_cell.sv
`timescale 1ns/10ps
module hpcg_pin_cell
  import hpcg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic usable_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  input wire logic dir_in,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  // readback
  output logic level_out
);
  logic latch;

  // output latch only loads when the direction bit selects output, even while the pin is not usable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      latch <= 1'b0; // RQ11
    end else if (wr_in && dir_in) begin
      latch <= wdata_in; // RQ3 RQ4
    end
  end

  assign pin_out = latch; // RQ4
  assign pin_oe_out = usable_in && dir_in; // RQ1 RQ5
  // input pins report the live level, outputs read back the latch
  assign level_out = dir_in ? latch : pin_in; // RQ2 RQ9
endmodule

//--- hpcg_pkg.sv
package hpcg_pkg;
  `include "hpcg_defs.svh"

  typedef struct packed {
    logic [`HPCG_NPINS-1:0] level;
    logic [`HPCG_NPINS-1:0] oe;
  } hpcg_pin_drive_t;

  typedef struct packed {
    logic [`HPCG_ADDR_W-1:0] addr;
    logic [`HPCG_REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } hpcg_bus_req_t;
endpackage
